// *** logic/microop_exec.sv ***
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "microops_defs.svh"

// =====================================================================
// Summary of operation
// - decimal sum stores each nybble carry
// - sum status only after operands touched
// - link from low-byte carry for 50-53
// - cycle-zero load-address loads storage address
// - register-option reference for 1E/1F or console
// - otherwise main-storage reference
// - insert one or two extra minor cycles
// - late load-address keeps address and reference kind
// - late load-address held until major end
// - every load-address loads operand A
// - plus commands load B, set force carry
// - minus commands load B, clear force carry
// - relocation copies segment tag into extension
// - load-data-word loads storage data register
// - cycle-one load-data-word starts full write
// - write address from storage address register
module microop_exec (
    input  wire logic                mclk_i,
    input  wire logic                rst_n_i,
    input  wire logic [3:0]          reg_addr_i,
    input  wire logic [15:0]         reg_wdata_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    input  wire logic                cmd_valid_i,
    input  wire microops_pkg::cmd_t  cmd_op_i,
    input  wire logic [15:0]         cmd_word_i,
    input  wire logic [2:0]          minor_cycle_i,
    input  wire logic                major_end_i,
    input  wire logic [3:0]          proc_state_i,
    input  wire logic                console_state_i,
    input  wire logic                console_ro_pos_i,
    input  wire logic [4:0]          reg_num_i,
    input  wire logic [15:0]         rf_rdata_i,
    input  wire logic [3:0]          seg_tag_i,
    input  wire logic                ext_file_i,
    input  wire logic                ext_addr_ok_i,
    input  wire logic                opnd_touch_i,
    input  wire logic [7:0]          sr_upper_i,
    input  wire logic                prot_ok_i,
    input  wire logic                read_major_i,
    input  wire logic                ro_ecc_i,
    input  wire logic [15:0]         mem_rdata_i,
    input  wire logic [15:0]         ro_rdata_i,
    output logic      [15:0]         reg_rdata_o,
    output logic                     rf_wr_o,
    output logic      [15:0]         rf_wr_data_o,
    output logic      [15:0]         rf_wr_mask_o,
    output logic      [15:0]         opa_o,
    output logic      [15:0]         opb_o,
    output logic                     force_carry_o,
    output logic      [15:0]         s_addr_o,
    output logic      [3:0]          s_ext_o,
    output logic      [15:0]         d_data_o,
    output logic      [15:0]         fanin_o,
    output logic                     mem_wr_o,
    output logic                     mem_wr_ro_o,
    output logic      [14:0]         wr_addr_o,
    output logic                     bkpt_bit_o,
    output logic                     ro_ref_o,
    output logic                     storage_rel_o,
    output logic      [1:0]          extra_cycles_o,
    output logic                     hold_valid_o,
    output logic      [15:0]         hold_one_o,
    output logic      [15:0]         hold_two_o,
    output logic      [3:0]          inner_carry_o,
    output logic                     ovf_o,
    output logic                     link_o
);

    // =====================================================================
    // command decode
    logic        go;
    logic        la_cmd;
    logic        ld_cmd;
    logic        e0;
    logic        e1;
    logic        ro_cond;
    logic        cmp_cmd;
    logic        dsum_cmd;
    logic        wr_start;
    logic        la_e0_r;
    logic        touched_r;
    logic [2:0]  cfg_r;

    assign go       = cmd_valid_i;
    assign e0       = minor_cycle_i == `MC_ZERO;
    assign e1       = minor_cycle_i == `MC_ONE;
    assign la_cmd   = cmd_op_i inside {microops_pkg::LOAD_ADDR_PLUS_ONE_CMD,
                                       microops_pkg::LOAD_ADDR_MINUS_ONE_CMD,
                                       microops_pkg::LOAD_ADDR_PLUS_TWO_CMD,
                                       microops_pkg::LOAD_ADDR_MINUS_TWO_CMD};
    assign ld_cmd   = cmd_op_i inside {microops_pkg::LOAD_DATA_WORD_CMD,
                                       microops_pkg::LOAD_DATA_COMPLEMENT_CMD,
                                       microops_pkg::LOAD_DATA_BYTE_CMD};
    assign cmp_cmd  = cmd_op_i inside {microops_pkg::SIGNED_COMPARE_CMD,
                                       microops_pkg::UNSIGNED_COMPARE_CMD};
    assign dsum_cmd = cmd_op_i == microops_pkg::DECIMAL_SUM_CMD;

    // register-option when 1E/1F in states 0-7 or console switch at option
    assign ro_cond  = (!console_state_i && !proc_state_i[3] &&
                       reg_num_i[4:1] == `REG_NUM_RO_HI) ||
                      (console_state_i && console_ro_pos_i);

    assign wr_start = go && cmd_op_i == microops_pkg::LOAD_DATA_WORD_CMD &&
                      e1 && la_e0_r && prot_ok_i;

    // =====================================================================
    // adder for decimal sum: cumulative nybble carries
    logic [4:0]  s4;
    logic [8:0]  s8;
    logic [12:0] s12;
    logic [16:0] s16;
    logic        in_window;

    assign s4  = {1'b0, opa_o[3:0]}  + {1'b0, opb_o[3:0]}  + {4'h0, force_carry_o};
    assign s8  = {1'b0, opa_o[7:0]}  + {1'b0, opb_o[7:0]}  + {8'h00, force_carry_o};
    assign s12 = {1'b0, opa_o[11:0]} + {1'b0, opb_o[11:0]} + {12'h000, force_carry_o};
    assign s16 = {1'b0, opa_o}       + {1'b0, opb_o}       + {16'h0000, force_carry_o};
    assign in_window = sr_upper_i >= `SR_LINK_LO && sr_upper_i <= `SR_LINK_HI;

    // =====================================================================
    // compare status
    logic [15:0] cmp_status;

    compare_gen u_compare_gen (
        .opa_i       (opa_o),
        .opb_i       (opb_o),
        .signed_en_i (cmd_op_i == microops_pkg::SIGNED_COMPARE_CMD),
        .status_o    (cmp_status)
    );

    // =====================================================================
    // software registers: feature configuration and status readback
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cfg_r <= `CFG_RST;
        end else if (reg_wr_i && reg_addr_i == `REG_CFG_OFF) begin
            cfg_r <= reg_wdata_i[2:0];
        end
    end

    // read data valid the cycle after the strobe, zero otherwise
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= `WORD_RST;
        end else if (reg_rd_i && reg_addr_i == `REG_CFG_OFF) begin
            reg_rdata_o <= {13'h0000, cfg_r};
        end else if (reg_rd_i && reg_addr_i == `REG_STAT_OFF) begin
            reg_rdata_o <= {8'h00, inner_carry_o, ovf_o, link_o, ro_ref_o, hold_valid_o};
        end else begin
            reg_rdata_o <= `WORD_RST;
        end
    end

    // =====================================================================
    // operand registers and force carry
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            opa_o         <= `WORD_RST;
            opb_o         <= `WORD_RST;
            force_carry_o <= 1'b0;
        end else if (go && la_cmd) begin
            opa_o <= rf_rdata_i;
            unique case (cmd_op_i)
                microops_pkg::LOAD_ADDR_PLUS_ONE_CMD: begin
                    opb_o         <= `B_PLUS_ONE;
                    force_carry_o <= 1'b1;
                end
                microops_pkg::LOAD_ADDR_PLUS_TWO_CMD: begin
                    opb_o         <= `B_PLUS_TWO;
                    force_carry_o <= 1'b1;
                end
                microops_pkg::LOAD_ADDR_MINUS_ONE_CMD: begin
                    opb_o         <= `B_MINUS_ONE;
                    force_carry_o <= 1'b0;
                end
                default: begin
                    opb_o         <= `B_MINUS_TWO;
                    force_carry_o <= 1'b0;
                end
            endcase
        end
    end

    // operands touched since the last digit or status clear; touch wins
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            touched_r <= 1'b0;
        end else if (opnd_touch_i || (go && la_cmd)) begin
            touched_r <= 1'b1;
        end else if (go && (cmd_op_i == microops_pkg::DIGIT_CMD ||
                            cmd_op_i == microops_pkg::STATUS_CLEAR_CMD)) begin
            touched_r <= 1'b0;
        end
    end

    // =====================================================================
    // decimal sum carries and arithmetic status
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            inner_carry_o <= `CARRY_RST;
            ovf_o         <= 1'b0;
            link_o        <= 1'b0;
        end else if (go && dsum_cmd) begin
            inner_carry_o <= {s16[16], s12[12], s8[8], s4[4]};
            if (touched_r) begin
                ovf_o  <= (opa_o[15] == opb_o[15]) && (s16[15] != opa_o[15]);
                link_o <= in_window ? s8[8] : s16[16];
            end
        end
    end

    // =====================================================================
    // register-file write port: sum or compare status
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rf_wr_o      <= 1'b0;
            rf_wr_data_o <= `WORD_RST;
            rf_wr_mask_o <= `WORD_RST;
        end else begin
            rf_wr_o <= go && (cmp_cmd || dsum_cmd);
            if (go && cmp_cmd) begin
                rf_wr_data_o <= cmp_status;
                rf_wr_mask_o <= (ext_file_i && ext_addr_ok_i) ? `CMP_MASK_FULL
                                                              : `CMP_MASK_BASIC;
            end else if (go && dsum_cmd) begin
                rf_wr_data_o <= s16[15:0];
                rf_wr_mask_o <= `CMP_MASK_FULL;
            end
        end
    end

    // =====================================================================
    // storage address, segment extension and reference kind
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            s_addr_o <= `WORD_RST;
            s_ext_o  <= `EXT_RST;
            ro_ref_o <= 1'b0;
        end else if (go && la_cmd && e0) begin
            s_addr_o <= rf_rdata_i;
            ro_ref_o <= ro_cond;
            if (cfg_r[`CFG_RELOC_BIT]) begin
                s_ext_o <= seg_tag_i;
            end
        end
    end

    // cycle-zero load-address seen in this major cycle; a new one wins
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            la_e0_r <= 1'b0;
        end else if (go && la_cmd && e0) begin
            la_e0_r <= 1'b1;
        end else if (major_end_i) begin
            la_e0_r <= 1'b0;
        end
    end

    // extra minor cycles request, one cycle after the load-address
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            extra_cycles_o <= `EXTRA_NONE;
        end else if (go && la_cmd && e0) begin
            if ((cfg_r[`CFG_PROT_BIT] || cfg_r[`CFG_RELOC_BIT]) && cfg_r[`CFG_ECC_BIT]) begin
                extra_cycles_o <= `EXTRA_TWO;
            end else if (|cfg_r) begin
                extra_cycles_o <= `EXTRA_ONE;
            end else begin
                extra_cycles_o <= `EXTRA_NONE;
            end
        end else begin
            extra_cycles_o <= `EXTRA_NONE;
        end
    end

    // storage-related flag for this cycle's command
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            storage_rel_o <= 1'b0;
        end else begin
            storage_rel_o <= go && (la_cmd || (ld_cmd && e1 && la_e0_r));
        end
    end

    // =====================================================================
    // hold registers for a late load-address; a new hold wins over the end
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            hold_valid_o <= 1'b0;
            hold_one_o   <= `WORD_RST;
            hold_two_o   <= `WORD_RST;
        end else if (go && la_cmd && !e0) begin
            hold_valid_o <= 1'b1;
            hold_one_o   <= cmd_word_i;
            hold_two_o   <= cmd_word_i;
        end else if (major_end_i) begin
            hold_valid_o <= 1'b0;
        end
    end

    // =====================================================================
    // storage data register and write start
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            d_data_o <= `WORD_RST;
        end else if (go && ld_cmd) begin
            d_data_o <= (cmd_op_i == microops_pkg::LOAD_DATA_COMPLEMENT_CMD) ? ~rf_rdata_i
                                                                             : rf_rdata_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            mem_wr_o    <= 1'b0;
            mem_wr_ro_o <= 1'b0;
            wr_addr_o   <= 15'h0000;
            bkpt_bit_o  <= 1'b0;
        end else begin
            mem_wr_o <= wr_start;
            if (wr_start) begin
                mem_wr_ro_o <= ro_ref_o;
                wr_addr_o   <= s_addr_o[15:1];
                bkpt_bit_o  <= s_addr_o[0];
            end
        end
    end

    // =====================================================================
    // data fan-in, registered
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            fanin_o <= `WORD_RST;
        end else if (read_major_i && minor_cycle_i >= `MC_FANIN_FIRST) begin
            fanin_o <= (ro_ref_o && !ro_ecc_i) ? ro_rdata_i : mem_rdata_i;
        end else begin
            fanin_o <= d_data_o;
        end
    end

    // =====================================================================
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    chk_sar_load: assert property (go && la_cmd && e0 |=> s_addr_o == $past(rf_rdata_i))
        else $error("storage address not loaded");
    chk_sar_keep: assert property (go && la_cmd && !e0 && !$past(go && la_cmd && e0)
        |=> $stable(s_addr_o) && $stable(ro_ref_o))
        else $error("late load-address changed address or kind");
    chk_ro_kind: assert property (go && la_cmd && e0 |=> ro_ref_o == $past(ro_cond))
        else $error("reference kind wrong");
    chk_opa_load: assert property (go && la_cmd |=> opa_o == $past(rf_rdata_i))
        else $error("operand A not loaded");
    chk_plus_two: assert property (go && cmd_op_i == microops_pkg::LOAD_ADDR_PLUS_TWO_CMD
        |=> opb_o == 16'h0001 && force_carry_o)
        else $error("plus-two operand wrong");
    chk_minus_two: assert property (go && cmd_op_i == microops_pkg::LOAD_ADDR_MINUS_TWO_CMD
        |=> opb_o == 16'hfffe && !force_carry_o)
        else $error("minus-two operand wrong");
    chk_hold_kept: assert property (go && la_cmd && !e0 |=> hold_valid_o
        ##1 (hold_valid_o || $past(major_end_i)))
        else $error("hold dropped early");
    chk_write_start: assert property (wr_start |=> mem_wr_o && d_data_o == $past(rf_rdata_i)
        && wr_addr_o == $past(s_addr_o[15:1]))
        else $error("write not started");
    chk_cmp_layout: assert property (go && cmp_cmd |=> rf_wr_o && rf_wr_data_o[7:0] == 8'hff
        && !rf_wr_data_o[15] && !rf_wr_data_o[11])
        else $error("compare layout wrong");
    chk_cmp_mask: assert property (go && cmp_cmd && !ext_file_i |=> rf_wr_mask_o == 16'hff00)
        else $error("basic file mask wrong");
    chk_ucmp_only: assert property (go && cmd_op_i == microops_pkg::UNSIGNED_COMPARE_CMD
        |=> rf_wr_data_o[14:12] == 3'h0)
        else $error("unsigned compare wrote signed bits");
    chk_extra_two: assert property (go && la_cmd && e0 && cfg_r[`CFG_ECC_BIT] && cfg_r[`CFG_PROT_BIT]
        |=> extra_cycles_o == 2'h2 ##1 extra_cycles_o == 2'h0 || go)
        else $error("extra cycle count wrong");
    chk_link_low: assert property (go && dsum_cmd && touched_r && in_window
        |=> link_o == $past(s8[8]))
        else $error("link not from low byte");
    chk_status_keep: assert property (go && dsum_cmd && !touched_r |=> $stable(ovf_o) && $stable(link_o))
        else $error("status changed without touch");

    cov_write: cover property (go && la_cmd && e0 ##1 wr_start);
    cov_late_la: cover property (go && la_cmd && !e0 ##[1:8] major_end_i);
    cov_ro_read: cover property (read_major_i && ro_ref_o && minor_cycle_i == 3'h4);

endmodule

// *** shared/microops_defs.svh ***
`ifndef MICROOPS_DEFS_SVH
`define MICROOPS_DEFS_SVH

// =====================================================================
// software register offsets and fields
`define REG_CFG_OFF       4'h0
`define REG_STAT_OFF      4'h1
`define CFG_PROT_BIT      0
`define CFG_RELOC_BIT     1
`define CFG_ECC_BIT       2
`define CFG_RST           3'h0

// =====================================================================
// minor cycle numbers
`define MC_ZERO           3'h0
`define MC_ONE            3'h1
`define MC_FANIN_FIRST    3'h4
`define MC_FANIN_LAST     3'h7

// =====================================================================
// operand constants loaded by the load-address commands
`define B_PLUS_ONE        16'h0000
`define B_PLUS_TWO        16'h0001
`define B_MINUS_ONE       16'hffff
`define B_MINUS_TWO       16'hfffe

// =====================================================================
// resource register window that moves the link to the low-byte carry
`define SR_LINK_LO        8'h50
`define SR_LINK_HI        8'h53

// =====================================================================
// compare status layout (doc bit 0 is the left-most, here bit 15)
`define CMP_SGT_POS       14
`define CMP_SLT_POS       13
`define CMP_SEQ_POS       12
`define CMP_UGT_POS       10
`define CMP_ULT_POS       9
`define CMP_UEQ_POS       8
`define CMP_LOW_ONES      8'hff
`define CMP_MASK_BASIC    16'hff00
`define CMP_MASK_FULL     16'hffff

// =====================================================================
// reset values, extra-cycle codes and the register-option number
`define WORD_RST          16'h0000
`define EXT_RST           4'h0
`define CARRY_RST         4'h0
`define EXTRA_NONE        2'h0
`define EXTRA_ONE         2'h1
`define EXTRA_TWO         2'h2
`define REG_NUM_RO_HI     4'hf

`endif

// *** shared/microops_pkg.sv ***
package microops_pkg;

    // micro-commands handled by this block
    typedef enum logic [3:0] {
        NO_CMD,
        DECIMAL_SUM_CMD,
        SIGNED_COMPARE_CMD,
        UNSIGNED_COMPARE_CMD,
        LOAD_ADDR_PLUS_ONE_CMD,
        LOAD_ADDR_MINUS_ONE_CMD,
        LOAD_ADDR_PLUS_TWO_CMD,
        LOAD_ADDR_MINUS_TWO_CMD,
        LOAD_DATA_WORD_CMD,
        LOAD_DATA_COMPLEMENT_CMD,
        LOAD_DATA_BYTE_CMD,
        DIGIT_CMD,
        STATUS_CLEAR_CMD
    } cmd_t;

endpackage

// *** logic/compare_gen.sv ***
`timescale 1ns/1ps
`include "microops_defs.svh"

module compare_gen (
    input  wire logic [15:0] opa_i,
    input  wire logic [15:0] opb_i,
    input  wire logic        signed_en_i,
    output logic      [15:0] status_o
);

    // =====================================================================
    // compare status word
    logic sgt;
    logic slt;
    logic ugt;
    logic ult;
    logic eq;

    assign sgt = $signed(opa_i) > $signed(opb_i);
    assign slt = $signed(opa_i) < $signed(opb_i);
    assign ugt = opa_i > opb_i;
    assign ult = opa_i < opb_i;
    assign eq  = opa_i == opb_i;

    // signed bits only when the signed command asks; bits 15 and 11 stay zero
    always_comb begin
        status_o                 = {8'h00, `CMP_LOW_ONES};
        status_o[`CMP_SGT_POS]   = signed_en_i & sgt;
        status_o[`CMP_SLT_POS]   = signed_en_i & slt;
        status_o[`CMP_SEQ_POS]   = signed_en_i & eq;
        status_o[`CMP_UGT_POS]   = ugt;
        status_o[`CMP_ULT_POS]   = ult;
        status_o[`CMP_UEQ_POS]   = eq;
    end

endmodule

// *** dv/storage_model.sv ***
`timescale 1ns/1ps
// =====================================================================
// main storage and register option behind the storage registers
module storage_model (
    input  wire logic        mclk_i,
    input  wire logic        wr_i,
    input  wire logic        wr_ro_i,
    input  wire logic [14:0] wr_addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic [15:0] raddr_i,
    input  wire logic        rd_i,
    output logic      [15:0] mem_o,
    output logic      [15:0] ro_o
);
    logic [15:0] mem_r [16];
    logic [15:0] ro_r  [16];
    // word writes land in storage or in option space
    always_ff @(posedge mclk_i) begin
        if (wr_i && !wr_ro_i) begin
            mem_r[wr_addr_i[3:0]] <= wdata_i;
        end
        if (wr_i && wr_ro_i) begin
            ro_r[wr_addr_i[3:0]] <= wdata_i;
        end
    end
    // outside a read the lines show the inverse, so stale data never passes
    assign mem_o = rd_i ? mem_r[raddr_i[4:1]] : ~mem_r[raddr_i[4:1]];
    assign ro_o  = rd_i ? ro_r[raddr_i[4:1]] : ~ro_r[raddr_i[4:1]];
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
// =====================================================================
// micro-command execution bench
module tb_top;
    logic mclk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, cmd_valid_i = 0, major_end_i = 0, prot_ok_i = 1;
    logic console_state_i = 0, console_ro_pos_i = 0, ext_file_i = 0, read_major_i = 0;
    logic [3:0]  reg_addr_i = 0, proc_state_i = 0, seg_tag_i = 0;
    logic [15:0] reg_wdata_i = 0, cmd_word_i = 0, rf_rdata_i = 0, mem_rdata_i, ro_rdata_i;
    logic [2:0]  minor_cycle_i = 0;
    logic [4:0]  reg_num_i = 0;
    logic [7:0]  sr_upper_i = 0;
    microops_pkg::cmd_t cmd_op_i = microops_pkg::NO_CMD;
    logic [15:0] reg_rdata_o, rf_wr_data_o, rf_wr_mask_o, opa_o, opb_o, s_addr_o, d_data_o;
    logic [15:0] fanin_o, hold_one_o, hold_two_o;
    logic        rf_wr_o, force_carry_o, mem_wr_o, mem_wr_ro_o, bkpt_bit_o, ro_ref_o;
    logic        storage_rel_o, hold_valid_o, ovf_o, link_o;
    logic [3:0]  s_ext_o, inner_carry_o;
    logic [14:0] wr_addr_o;
    logic [1:0]  extra_cycles_o;
    int          err_total = 0, n_checks = 0;
    microops_pkg::cmd_t la[4] = '{microops_pkg::LOAD_ADDR_PLUS_ONE_CMD, microops_pkg::LOAD_ADDR_MINUS_ONE_CMD,
                                  microops_pkg::LOAD_ADDR_PLUS_TWO_CMD, microops_pkg::LOAD_ADDR_MINUS_TWO_CMD};
    logic [15:0] bx[4] = '{16'h0000, 16'hffff, 16'h0001, 16'hfffe};

    always #5 mclk_i = ~mclk_i;

    microop_exec i_dut (.*, .opnd_touch_i(1'b0), .ro_ecc_i(1'b0), .ext_addr_ok_i(ext_file_i));
    storage_model i_mem (.mclk_i(mclk_i), .wr_i(mem_wr_o), .wr_ro_i(mem_wr_ro_o), .wr_addr_i(wr_addr_o),
                         .wdata_i(d_data_o), .raddr_i(s_addr_o), .rd_i(read_major_i), .mem_o(mem_rdata_i),
                         .ro_o(ro_rdata_i));

    // =================================================================
    // shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge mclk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, exp);
    endtask
    // one command in one minor cycle, outputs checked just after it lands
    task automatic cmd(input microops_pkg::cmd_t op, input logic [2:0] mc, input logic [15:0] rf);
        @(posedge mclk_i);
        cmd_valid_i <= 1'b1;
        cmd_op_i <= op;
        minor_cycle_i <= mc;
        rf_rdata_i <= rf;
        cmd_word_i <= ~rf;
        @(posedge mclk_i);
        cmd_valid_i <= 1'b0;
        #1;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // =================================================================
    // watchdog
    initial begin
        #50000;
        err_total++;
        conclude();
    end

    // =================================================================
    // main sequence
    initial begin
        repeat (12) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rd(4'h0, 16'h0000);
        wr(4'h9, 16'hffff);
        rd(4'h9, 16'h0000);
        reg_num_i <= 5'h05;
        for (int i = 0; i < 4; i++) begin
            cmd(la[i], 3'h0, 16'h1230 + 16'(i));
            chk(s_addr_o, 16'h1230 + 16'(i));
            chk(opa_o, 16'h1230 + 16'(i));
            chk(opb_o, bx[i]);
            chk(16'(force_carry_o), 16'(i % 2 == 0));
            chk(16'(storage_rel_o), 16'h0001);
            chk(16'(extra_cycles_o), 16'h0000);
        end
        $display("test load address done");
        reg_num_i <= 5'h1e;
        cmd(la[0], 3'h0, 16'h0040);
        chk(16'(ro_ref_o), 16'h0001);
        reg_num_i <= 5'h05;
        cmd(microops_pkg::NO_CMD, 3'h2, 16'h0000);
        cmd(la[1], 3'h3, 16'h0077);
        chk(s_addr_o, 16'h0040);
        chk(16'(ro_ref_o), 16'h0001);
        chk(opa_o, 16'h0077);
        chk(16'(hold_valid_o), 16'h0001);
        chk(hold_two_o, 16'hff88);
        chk(hold_one_o, 16'hff88);
        major_end_i <= 1'b1;
        @(posedge mclk_i);
        major_end_i <= 1'b0;
        #1 chk(16'(hold_valid_o), 16'h0000);
        cmd(la[0], 3'h0, 16'h0040);
        chk(16'(ro_ref_o), 16'h0000);
        console_state_i <= 1'b1;
        console_ro_pos_i <= 1'b1;
        cmd(la[0], 3'h0, 16'h0040);
        chk(16'(ro_ref_o), 16'h0001);
        console_state_i <= 1'b0;
        console_ro_pos_i <= 1'b0;
        $display("test reference kind done");
        seg_tag_i <= 4'ha;
        wr(4'h0, 16'h0002);
        rd(4'h0, 16'h0002);
        cmd(la[0], 3'h0, 16'h0006);
        chk(16'(extra_cycles_o), 16'h0001);
        chk(16'(s_ext_o), 16'h000a);
        wr(4'h0, 16'h0005);
        cmd(la[2], 3'h0, 16'h0007);
        chk(16'(extra_cycles_o), 16'h0002);
        cmd(microops_pkg::LOAD_DATA_WORD_CMD, 3'h1, 16'hbeef);
        chk(d_data_o, 16'hbeef);
        chk(16'(mem_wr_o), 16'h0001);
        chk(16'(mem_wr_ro_o), 16'h0000);
        chk(16'(wr_addr_o), 16'h0003);
        chk(16'(bkpt_bit_o), 16'h0001);
        chk(16'(storage_rel_o), 16'h0001);
        cmd(la[0], 3'h0, 16'h0006);
        cmd(microops_pkg::LOAD_DATA_WORD_CMD, 3'h5, 16'h1111);
        chk(16'(mem_wr_o), 16'h0000);
        chk(16'(storage_rel_o), 16'h0000);
        prot_ok_i <= 1'b0;
        cmd(microops_pkg::LOAD_DATA_WORD_CMD, 3'h1, 16'h1111);
        chk(16'(mem_wr_o), 16'h0000);
        prot_ok_i <= 1'b1;
        read_major_i <= 1'b1;
        minor_cycle_i <= 3'h4;
        @(posedge mclk_i);
        #1 chk(fanin_o, 16'hbeef);
        minor_cycle_i <= 3'h3;
        @(posedge mclk_i);
        #1 chk(fanin_o, 16'h1111);
        read_major_i <= 1'b0;
        $display("test storage write done");
        cmd(la[0], 3'h0, 16'h8000);
        cmd(microops_pkg::SIGNED_COMPARE_CMD, 3'h1, 16'h0000);
        chk(16'(rf_wr_o), 16'h0001);
        chk(rf_wr_data_o, 16'h24ff);
        chk(rf_wr_mask_o, 16'hff00);
        ext_file_i <= 1'b1;
        cmd(microops_pkg::UNSIGNED_COMPARE_CMD, 3'h1, 16'h0000);
        chk(rf_wr_data_o, 16'h04ff);
        chk(rf_wr_mask_o, 16'hffff);
        $display("test compare done");
        cmd(la[2], 3'h0, 16'h00ff);
        cmd(microops_pkg::DECIMAL_SUM_CMD, 3'h1, 16'h0000);
        chk(16'(inner_carry_o), 16'h0003);
        chk(16'(link_o), 16'h0000);
        chk(16'(ovf_o), 16'h0000);
        sr_upper_i <= 8'h50;
        cmd(microops_pkg::DECIMAL_SUM_CMD, 3'h2, 16'h0000);
        chk(16'(link_o), 16'h0001);
        cmd(microops_pkg::DIGIT_CMD, 3'h3, 16'h0000);
        sr_upper_i <= 8'h00;
        cmd(microops_pkg::DECIMAL_SUM_CMD, 3'h4, 16'h0000);
        chk(16'(link_o), 16'h0001);
        chk(16'(inner_carry_o), 16'h0003);
        $display("test decimal sum done");
        conclude();
    end
endmodule
